// ==== cpu_bus_model.sv ====
/*
 * processor bus master model that issues bus cycles into the memory mapper.
 * assumes the bench calls cycle() right after a rising edge of aclk.
 */
`timescale 1ns/1ps
module cpu_bus_model (
    input  wire logic        aclk,
    output logic             cpu_valid,
    output logic [23:0]      cpu_addr,
    output logic             cpu_write,
    output logic             cpu_dma,
    output logic [2:0]       code
);
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // idle bus: strobe low, qualifiers zero
    initial begin
        cpu_valid = 1'b0;
        cpu_addr  = 24'h0;
        cpu_write = 1'b0;
        cpu_dma   = 1'b0;
        code      = 3'h0;
    end
    // strobe for one clock after gap idle clocks, then scramble address, write and space code
    task automatic cycle(input logic [23:0] a, input logic w, d, input logic [2:0] c, input int gap);
        repeat (gap) @(posedge aclk);
        cpu_valid <= 1'b1;
        cpu_addr  <= a;
        cpu_write <= w;
        cpu_dma   <= d;
        code      <= c;
        @(posedge aclk);
        cpu_valid <= 1'b0;
        cpu_addr  <= ~a;
        cpu_write <= ~w;
        code      <= ~c;
    endtask
endmodule // cpu_bus_model

// ==== emulation_memory_mapper.sv ====
/*
 * emulation memory mapper: classifies each processor bus cycle into one of
 * the mapped ranges or the default type and steers it to emulation memory or the target bus.
 * assumes bus cycles and configuration come on aclk; registers over AXI4-Lite.
 */
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
// How it works
// - at most eight ranges, each with its own start, end and type.
// - ranges are in 256-byte units, so the low eight address bits are not compared.
// - emulation ranges take whole 64-Kbyte blocks, a partly used block is lost to others.
// - cycles from a DMA master never reach emulation memory.
// - each range is emulation RAM or ROM, target RAM or ROM, or guarded, which sets the route.
// - any access to a guarded range raises a break into the monitor.
// - a write to a ROM range breaks only while break-on-ROM-write is enabled.
// - writes to emulation ROM are blocked, except in in-target analysis mode or from a DMA master, where they go to the target.
// - writes to guarded ranges, or to target ROM with break-on-ROM-write set, break but still go to the target.
// - an unmatched address uses the default type, target RAM after reset.
// - the default type can only be target RAM, target ROM or guarded.
// - in in-target analysis mode all cycles go to the target.
// - emulation memory is 16 bits wide but a range may stand in for 8-bit memory.
// - editing ranges may reallocate blocks, so emulation contents are not kept.
// - a range may be qualified by the three space code bits, so overlaps split.
`timescale 1ns/1ps
module emulation_memory_mapper import mapper_pkg::*; #(
    parameter int NE = 8,  // range entries
    parameter int AW = 24, // processor address width
    parameter int NB = 8   // emulation memory blocks
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 cpu_valid,
    input  wire logic [AW-1:0]        cpu_addr,
    input  wire logic                 cpu_write,
    input  wire logic                 cpu_dma,
    input  wire logic                 space_code_bit0,
    input  wire logic                 space_code_bit1,
    input  wire logic                 space_code_bit2,
    output logic                      map_valid,
    output logic                      emu_sel,
    output logic                      emu_we,
    output logic [$clog2(NB)+15:0]    emu_addr,
    output logic                      emu_byte8,
    output logic                      tgt_sel,
    output logic                      tgt_we,
    output logic [AW-1:0]             tgt_addr,
    output logic                      wr_inhibit,
    output logic                      brk_req,
    output logic                      irq
);
    localparam int UW = AW - UNIT_BITS;
    localparam int BW = $clog2(NB);
    localparam int KW = AW - BLOCK_BITS;

    typedef struct packed {
        logic [NE-1:0][UW-1:0] st;
        logic [NE-1:0][UW-1:0] en;
        logic [NE-1:0][2:0]    ty;
        logic [NE-1:0][2:0]    fm;
        logic [NE-1:0][2:0]    fc;
        logic [NE-1:0]         b8;
        logic                  brk_rom;
        logic                  act;
        mem_type_e             dflt;
        logic [N_EV-1:0]       evs;
        logic [N_EV-1:0]       evm;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [1:0]            rresp;
        logic [31:0]           rdata;
        logic                  ov;
        logic                  owr;
        mem_type_e             oty;
        logic                  emu_sel;
        logic                  emu_we;
        logic [BW+15:0]        emu_addr;
        logic                  b8o;
        logic                  tgt_sel;
        logic                  tgt_we;
        logic [AW-1:0]         taddr;
        logic                  inh;
        logic                  brk;
    } state_s;

    state_s q;
    state_s d;

    // -------------------------------------------------------------------
    // block allocation and range match
    // -------------------------------------------------------------------
    logic [NE-1:0][KW:0] base;
    logic [NE-1:0]       ok;
    logic [NE-1:0]       hit;
    logic [2:0]          scode;

    assign scode = {space_code_bit2, space_code_bit1, space_code_bit0};

    // blocks are handed out in entry order; re-evaluated on every edit
    always_comb begin
        logic [KW:0] acc, need;
        acc = '0;
        need = '0;
        for (int i = 0; i < NE; i++) begin
            need = {1'b0, q.en[i][UW-1:UW-KW]} - {1'b0, q.st[i][UW-1:UW-KW]} + 1'b1;
            base[i] = acc;
            ok[i] = (q.en[i] >= q.st[i]) && ({1'b0, acc} + need <= (KW+2)'(NB));
            if ((q.ty[i] == EMU_RAM || q.ty[i] == EMU_ROM) && ok[i]) begin
                acc = acc + need;
            end
        end
    end

    // one comparator per entry; low eight address bits ignored
    for (genvar g = 0; g < NE; g++) begin : g_match
        assign hit[g] = cpu_addr[AW-1:UNIT_BITS] >= q.st[g] && cpu_addr[AW-1:UNIT_BITS] <= q.en[g]
                        && ((scode ^ q.fc[g]) & q.fm[g]) == 3'h0;
    end

    // register read value for a byte address
    function automatic logic [32:0] reg_rd(input state_s s, input logic [7:0] a,
                                          input logic [NE-1:0][KW:0] b, input logic [NE-1:0] k);
        logic [31:0] v;
        logic        e;
        int          i;
        v = '0;
        e = 1'b0;
        i = int'(a[6:4]);
        if (a[7]) begin
            unique case (a[3:2])
                F_START: v[AW-1:0] = {s.st[i], 8'h00};
                F_END:   v[AW-1:0] = {s.en[i], 8'hFF};
                F_ATTR:  v = {7'h00, k[i], b[i][7:0], 3'h0, s.b8[i], 1'b0, s.fc[i], 1'b0, s.fm[i], 1'b0, s.ty[i]};
                default: e = 1'b1;
            endcase
        end else if (a[6:4] != 3'h0) begin
            e = 1'b1;
        end else begin
            unique case (a[3:2])
                CTRL_OFF[3:2]: v[1:0] = {s.act, s.brk_rom};
                DFLT_OFF[3:2]: v[2:0] = s.dflt;
                STAT_OFF[3:2]: v[10:0] = {s.oty, 5'h00, s.evs};
                MASK_OFF[3:2]: v[2:0] = s.evm;
            endcase
        end
        return {e, v};
    endfunction

    // -------------------------------------------------------------------
    // next state: bus slave, routing and events
    // -------------------------------------------------------------------
    always_comb begin
        logic [32:0] cur;
        logic [31:0] wv;
        logic [N_EV-1:0] ev;
        mem_type_e   t;
        int          hi;
        int          wi;
        logic        h;
        logic        emu;
        d = q;
        ev = '0;
        wv = '0;
        hi = 0;
        h = 1'b0;
        t = q.dflt;
        wi = int'(s_axi_awaddr[6:4]);
        if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
        if (q.rvalid && s_axi_rready) d.rvalid = 1'b0;
        // write takes address and data together
        cur = reg_rd(q, s_axi_awaddr, base, ok);
        if (s_axi_awready) begin
            for (int b = 0; b < 4; b++) begin
                wv[8*b +: 8] = s_axi_wstrb[b] ? s_axi_wdata[8*b +: 8] : cur[8*b +: 8];
            end
            d.bvalid = 1'b1;
            d.bresp = cur[32] ? RESP_SLVERR : RESP_OKAY;
            if (s_axi_awaddr[7]) begin
                unique case (s_axi_awaddr[3:2])
                    F_START: d.st[wi] = wv[AW-1:UNIT_BITS];
                    F_END:   d.en[wi] = wv[AW-1:UNIT_BITS];
                    F_ATTR: begin
                        if (wv[2:0] <= 3'(EMU_ROM)) d.ty[wi] = wv[2:0];
                        d.fm[wi] = wv[AT_FMASK +: 3];
                        d.fc[wi] = wv[AT_FCODE +: 3];
                        d.b8[wi] = wv[AT_BYTE8];
                    end
                    default: ;
                endcase
            end else if (s_axi_awaddr[6:4] == 3'h0) begin
                unique case (s_axi_awaddr[3:2])
                    CTRL_OFF[3:2]: {d.act, d.brk_rom} = {wv[CTRL_ACT], wv[CTRL_BRK_ROM]};
                    DFLT_OFF[3:2]: if (wv[2:0] <= 3'(GUARD)) d.dflt = mem_type_e'(wv[2:0]);
                    MASK_OFF[3:2]: d.evm = wv[N_EV-1:0];
                    default: ;
                endcase
            end
        end
        // read; a status read clears the sticky events
        if (s_axi_arready && s_axi_arvalid) begin
            cur = reg_rd(q, s_axi_araddr, base, ok);
            d.rvalid = 1'b1;
            d.rdata = cur[31:0];
            d.rresp = cur[32] ? RESP_SLVERR : RESP_OKAY;
            if (s_axi_araddr == STAT_OFF) d.evs = '0;
        end
        // lowest matching entry wins, else the default type
        for (int i = NE-1; i >= 0; i--) begin
            if (hit[i]) begin
                h = 1'b1;
                hi = i;
            end
        end
        if (h) t = mem_type_e'(q.ty[hi]);
        emu = (t == EMU_RAM || t == EMU_ROM);
        if (emu && !ok[hi]) t = q.dflt;
        if (emu && (q.act || cpu_dma)) t = (t == EMU_ROM) ? TGT_ROM : TGT_RAM;
        emu = (t == EMU_RAM || t == EMU_ROM);
        d.ov = cpu_valid;
        if (cpu_valid) begin
            d.owr = cpu_write;
            d.oty = t;
            d.emu_sel = emu;
            d.emu_we = cpu_write && t == EMU_RAM;
            d.inh = cpu_write && t == EMU_ROM;
            d.tgt_sel = !emu;
            d.tgt_we = cpu_write && !emu;
            d.taddr = cpu_addr;
            d.b8o = emu && q.b8[hi];
            d.emu_addr = {BW'(base[hi] + (KW+1)'(cpu_addr[AW-1:BLOCK_BITS] - q.st[hi][UW-1:UW-KW])),
                          cpu_addr[BLOCK_BITS-1:0]};
            ev[EV_GUARD] = t == GUARD;
            ev[EV_ROMWR] = cpu_write && q.brk_rom && (t == TGT_ROM || t == EMU_ROM);
            ev[EV_DMA] = cpu_dma && h && (q.ty[hi] == EMU_RAM || q.ty[hi] == EMU_ROM);
            d.brk = ev[EV_GUARD] | ev[EV_ROMWR];
        end else begin
            {d.emu_sel, d.emu_we, d.inh, d.tgt_sel, d.tgt_we, d.brk} = '0;
        end
        d.evs = d.evs | ev; // set wins over clear
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.dflt <= DFLT_RST;
            q.oty <= DFLT_RST;
        end else begin
            q <= d;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !q.bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign map_valid     = q.ov;
    assign emu_sel       = q.emu_sel;
    assign emu_we        = q.emu_we;
    assign emu_addr      = q.emu_addr;
    assign emu_byte8     = q.b8o;
    assign tgt_sel       = q.tgt_sel;
    assign tgt_we        = q.tgt_we;
    assign tgt_addr      = q.taddr;
    assign wr_inhibit    = q.inh;
    assign brk_req       = q.brk;
    assign irq           = |(q.evs & q.evm);

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_guard;
        q.ov && q.oty == GUARD |-> brk_req && q.evs[EV_GUARD];
    endproperty
    a_guard: assert property (p_guard) else $error("guarded access without break");
    property p_rom_brk;
        q.ov && q.owr && (q.oty == TGT_ROM || q.oty == EMU_ROM) |-> brk_req == $past(q.brk_rom);
    endproperty
    a_rom_brk: assert property (p_rom_brk) else $error("rom write break wrong");
    property p_inhibit;
        q.ov && q.owr && q.oty == EMU_ROM |-> wr_inhibit && !emu_we && !tgt_we;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("emulation rom write not blocked");
    property p_tgt_pass;
        q.ov && q.owr && (q.oty == TGT_ROM || q.oty == GUARD) |-> tgt_we && tgt_sel;
    endproperty
    a_tgt_pass: assert property (p_tgt_pass) else $error("target write dropped");
    property p_dma;
        cpu_valid && cpu_dma |=> tgt_sel && !emu_sel;
    endproperty
    a_dma: assert property (p_dma) else $error("dma reached emulation memory");
    property p_act;
        cpu_valid && q.act |=> !emu_sel && tgt_sel;
    endproperty
    a_act: assert property (p_act) else $error("emulation used in analysis mode");
    property p_dflt;
        q.dflt inside {TGT_RAM, TGT_ROM, GUARD};
    endproperty
    a_dflt: assert property (p_dflt) else $error("illegal default type");
    property p_unit;
        cpu_valid |=> tgt_addr == $past(cpu_addr) && emu_addr[UNIT_BITS-1:0] == $past(cpu_addr[UNIT_BITS-1:0]);
    endproperty
    a_unit: assert property (p_unit) else $error("address offset lost");
    property p_nohit;
        cpu_valid && hit == '0 |=> q.oty == $past(q.dflt);
    endproperty
    a_nohit: assert property (p_nohit) else $error("default type not used");
    property p_pulse;
        !cpu_valid |=> !emu_sel && !tgt_sel && !brk_req;
    endproperty
    a_pulse: assert property (p_pulse) else $error("route without cycle");

    c_guard: cover property (q.ov && q.oty == GUARD);
    c_emu_wr: cover property (emu_we);
    c_inhibit: cover property (wr_inhibit && brk_req);
    c_irq: cover property (irq ##1 s_axi_rvalid ##1 !irq);
endmodule // emulation_memory_mapper

// ==== mapper_pkg.sv ====
/*
 * constants, memory types and register layout of the memory mapper.
 * assumes a 32-bit AXI4-Lite register bus with 8 byte-address bits.
 */
package mapper_pkg;
    // memory types of a range
    typedef enum logic [2:0] {
        TGT_RAM = 3'h0,
        TGT_ROM = 3'h1,
        GUARD   = 3'h2,
        EMU_RAM = 3'h3,
        EMU_ROM = 3'h4
    } mem_type_e;
    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] DFLT_OFF   = 8'h04;
    localparam logic [7:0] STAT_OFF   = 8'h08;
    localparam logic [7:0] MASK_OFF   = 8'h0C;
    localparam logic [7:0] ENTRY_BASE = 8'h80; // entry i at base + 16*i
    localparam logic [1:0] F_START    = 2'h0;
    localparam logic [1:0] F_END      = 2'h1;
    localparam logic [1:0] F_ATTR     = 2'h2;
    // field positions
    localparam int CTRL_BRK_ROM = 0;
    localparam int CTRL_ACT     = 1;
    localparam int AT_TYPE      = 0;  // [2:0]
    localparam int AT_FMASK     = 4;  // [6:4]
    localparam int AT_FCODE     = 8;  // [10:8]
    localparam int AT_BYTE8     = 12;
    localparam int AT_BASE      = 16; // [23:16] read only
    localparam int AT_OK        = 24; // read only
    localparam int ST_LAST      = 8;  // [10:8] last type
    // status event bits
    localparam int EV_GUARD = 0;
    localparam int EV_ROMWR = 1;
    localparam int EV_DMA   = 2;
    localparam int N_EV     = 3;
    // values after reset and sizes
    localparam mem_type_e DFLT_RST = TGT_RAM;
    localparam int UNIT_BITS  = 8;  // 256-byte units
    localparam int BLOCK_BITS = 16; // 64-Kbyte blocks
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== tb_top.sv ====
/*
 * self-checking bench of the memory mapper: range table, routing, breaks, irq.
 * assumes mapper_pkg and a 200 MHz aclk; registers over AXI4-Lite.
 */
`timescale 1ns/1ps
module tb_top import mapper_pkg::*;;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, cpu_valid, cpu_write, cpu_dma;
    logic        map_valid, emu_sel, emu_we, emu_byte8, tgt_sel, tgt_we, wr_inhibit, brk_req, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, resp;
    logic [23:0] cpu_addr, tgt_addr;
    logic [18:0] emu_addr;
    logic [2:0]  code;
    logic [23:0] ts[8], te[8];
    mem_type_e   tt[8], dflt;
    logic [2:0]  tm[8], tv[8];
    logic        brom, act;
    int          err_total, num_checks, cyc, i, ph;
    logic [23:0] corner[12] = '{24'h001000, 24'h004FFF, 24'h005000, 24'h008FFF, 24'h009000, 24'h00A0FF,
                                24'h00A100, 24'h00C000, 24'h00CFFF, 24'h03FFFF, 24'h040000, 24'h000F00};
    emulation_memory_mapper dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .cpu_write(cpu_write), .cpu_dma(cpu_dma),
        .space_code_bit0(code[0]), .space_code_bit1(code[1]), .space_code_bit2(code[2]),
        .map_valid(map_valid), .emu_sel(emu_sel), .emu_we(emu_we), .emu_addr(emu_addr),
        .emu_byte8(emu_byte8), .tgt_sel(tgt_sel), .tgt_we(tgt_we), .tgt_addr(tgt_addr),
        .wr_inhibit(wr_inhibit), .brk_req(brk_req), .irq(irq));
    cpu_bus_model cpu (.aclk(aclk), .cpu_valid(cpu_valid), .cpu_addr(cpu_addr), .cpu_write(cpu_write),
        .cpu_dma(cpu_dma), .code(code));
    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    always #2.5 aclk = ~aclk;
    // cut a hang short
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // register write: address and data offered together, wait for response
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic aw_open;
        logic w_open;
        aw_open = 1'b1;
        w_open  = 1'b1;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // each channel is released at the edge that takes it
        while (aw_open || w_open) begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            aw_open = aw_open && awready !== 1'b1;
            w_open  = w_open && wready !== 1'b1;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        resp = bresp;
    endtask
    // register read into rd and resp
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        resp = rresp;
    endtask
    // expected {byte8, block, emu_sel, emu_we, tgt_sel, tgt_we, inhibit, break}
    function automatic logic [9:0] expect_map(logic [23:0] a, logic w, d, logic [2:0] c);
        mem_type_e t;
        logic [2:0] blk, base;
        logic       hit, b8, emu;
        t = dflt;
        blk = 3'h0;
        base = 3'h0;
        hit = 1'b0;
        b8 = 1'b0;
        for (int k = 0; k < 8; k++) begin
            if (!hit && a[23:8] >= ts[k][23:8] && a[23:8] <= te[k][23:8] && ((c ^ tv[k]) & tm[k]) == 3'h0) begin
                hit = 1'b1;
                t = tt[k];
                b8 = (k == 5);
                blk = base + 3'(a[23:16] - ts[k][23:16]);
            end
            if (tt[k] inside {EMU_RAM, EMU_ROM}) base += 3'(te[k][23:16] - ts[k][23:16] + 8'h1);
        end
        if ((d || act) && t == EMU_RAM) t = TGT_RAM;
        if ((d || act) && t == EMU_ROM) t = TGT_ROM;
        emu = t inside {EMU_RAM, EMU_ROM};
        return {b8, blk, emu, emu && w && t == EMU_RAM, !emu, !emu && w, w && t == EMU_ROM,
                t == GUARD || (w && brom && t inside {TGT_ROM, EMU_ROM})};
    endfunction
    // one processor cycle and the comparison of the mapped outputs, with only the emulation or the target address per route
    task automatic map_chk(input logic [23:0] a, input logic w, d, input logic [2:0] c);
        logic [9:0] e;
        e = expect_map(a, w, d, c);
        cpu.cycle(a, w, d, c, 1 + ($urandom % 2));
        #1;
        chk(map_valid, 1'b1);
        chk({emu_sel, emu_we, tgt_sel, tgt_we, wr_inhibit, brk_req}, e[5:0]);
        if (e[5]) chk({emu_byte8, emu_addr}, {e[9], e[8:6], a[15:0]});
        else chk(tgt_addr, a);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0000000000F;
        ts = '{24'h001000, 24'h007000, 24'h00A000, 24'h00C000, 24'h00C000, 24'h020000, 24'h0, 24'h0};
        te = '{24'h004FFF, 24'h008FFF, 24'h00A0FF, 24'h00CFFF, 24'h00CFFF, 24'h03FFFF, 24'h0, 24'h0};
        tt = '{EMU_ROM, EMU_RAM, GUARD, TGT_ROM, GUARD, EMU_RAM, TGT_RAM, TGT_RAM};
        tm = '{3'h0, 3'h0, 3'h0, 3'h7, 3'h7, 3'h0, 3'h0, 3'h0};
        tv = '{3'h0, 3'h0, 3'h0, 3'h5, 3'h1, 3'h0, 3'h0, 3'h0};
        brom = 1'b0;
        act  = 1'b0;
        dflt = TGT_RAM;
        void'($urandom(32'hB8441969));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        #1 chk({map_valid, irq}, 2'h0);
        axr(DFLT_OFF);
        chk(rd, 32'(TGT_RAM));
        axw(DFLT_OFF, 32'(EMU_RAM));
        axw(DFLT_OFF, 32'(EMU_ROM));
        chk(resp, RESP_OKAY);
        axr(DFLT_OFF);
        chk(rd, 32'(TGT_RAM));
        axr(8'h8C);
        chk(resp, RESP_SLVERR);
        axw(8'h40, 32'h0);
        chk(resp, RESP_SLVERR);
        $display("test reset_regs done");
        // load six ranges, low byte of start deliberately dirty
        for (i = 0; i < 6; i++) begin
            axw(ENTRY_BASE + 8'(16 * i), 32'(ts[i] | 24'h5A));
            axw(ENTRY_BASE + 8'(16 * i + 4), 32'(te[i]));
            axw(ENTRY_BASE + 8'(16 * i + 8), 32'(tt[i]) | (32'(tm[i]) << AT_FMASK) | (32'(tv[i]) << AT_FCODE)
                | (32'(i == 5) << AT_BYTE8));
        end
        axr(ENTRY_BASE);
        chk(rd, 32'h001000);
        axr(ENTRY_BASE + 8'h4);
        chk(rd, 32'h004FFF);
        axr(ENTRY_BASE + 8'h58);
        chk(rd[24:16], 9'h102);
        foreach (corner[k]) for (int w = 0; w < 2; w++) map_chk(corner[k], w[0], 1'b0, 3'(k % 8));
        map_chk(24'h00C010, 1'b1, 1'b0, 3'h5);
        map_chk(24'h00C010, 1'b1, 1'b0, 3'h1);
        $display("test ranges done");
        // random cycles under each control setting, then with the default set to guarded
        for (ph = 0; ph < 5; ph++) begin
            brom = ph[0];
            act = ph[1];
            dflt = (ph == 4) ? GUARD : TGT_RAM;
            axw(CTRL_OFF, {30'h0, act, brom});
            axw(DFLT_OFF, 32'(dflt));
            repeat (60) map_chk(ts[$urandom % 6] + 24'($urandom % 32'h2000) - 24'h80, 1'($urandom),
                                ($urandom % 8) == 0, 3'($urandom));
        end
        $display("test random done");
        // interrupt: raise, clear by read, mask
        axr(STAT_OFF);
        axw(MASK_OFF, 32'h7);
        map_chk(24'h00A010, 1'b0, 1'b0, 3'h0);
        @(posedge aclk);
        #1 chk(irq, 1'b1);
        axr(STAT_OFF);
        chk(rd[10:0], {3'(GUARD), 5'h0, 3'h1});
        #1 chk(irq, 1'b0);
        axw(MASK_OFF, 32'h6);
        map_chk(24'h00A010, 1'b0, 1'b0, 3'h0);
        @(posedge aclk);
        #1 chk(irq, 1'b0);
        map_chk(24'h007010, 1'b1, 1'b1, 3'h0);
        @(posedge aclk);
        #1 chk(irq, 1'b1);
        axr(STAT_OFF);
        chk(rd[2:0], 3'h5);
        $display("test irq done");
        // an emulation range wider than the free blocks falls back to the default type
        axw(ENTRY_BASE + 8'h64, 32'h4FFFFF);
        axw(ENTRY_BASE + 8'h68, 32'(EMU_RAM));
        axr(ENTRY_BASE + 8'h68);
        chk(rd[24:16], 9'h004);
        cpu.cycle(24'h300000, 1'b1, 1'b0, 3'h0, 1);
        #1 chk({emu_sel, tgt_sel, brk_req}, 3'h3);
        $display("test overflow done");
        final_report();
    end
endmodule // tb_top
